// >>> core/epv_pkg.sv
// Package for the PROM programmer: register map, pin timing and command codes
package epv_pkg;
   // Register byte offsets on the AHB-Lite slave
   localparam logic [7:0] EPV_OFF_CTRL = 8'h00;
   localparam logic [7:0] EPV_OFF_ADDR = 8'h04;
   localparam logic [7:0] EPV_OFF_DATA = 8'h08;
   localparam logic [7:0] EPV_OFF_STAT = 8'h0C;
   localparam logic [7:0] EPV_OFF_RDAT = 8'h10;
   localparam logic [7:0] EPV_OFF_OPT = 8'h14;
   // Control register command field, bits [2:0], with go in bit 31
   localparam int EPV_CTRL_GO_BIT = 31;
   localparam logic [2:0] EPV_CMD_PROG = 3'h1;
   localparam logic [2:0] EPV_CMD_VERIFY = 3'h2;
   localparam logic [2:0] EPV_CMD_IDENT = 3'h3;
   localparam logic [2:0] EPV_CMD_EXPR = 3'h4;
   // Option register fields
   localparam int EPV_OPT_SEL_LSB = 0;
   localparam int EPV_OPT_CODE_BIT = 4;
   localparam int EPV_OPT_MULT_LSB = 8;
   // Widths and counts
   localparam int EPV_AW = 14;
   localparam int EPV_DW = 16;
   localparam int EPV_NDEV = 4;
   localparam int EPV_IDW = 8;
   localparam logic [3:0] EPV_EXPR_MAX = 4'hA;
   localparam logic [7:0] EPV_FAST_MAX = 8'h19;
   localparam logic [7:0] EPV_OPW_MULT_DEF = 8'h03;
   // Times, in nanoseconds, with the clock period
   localparam int EPV_CLK_NS = 100;
   localparam int EPV_SETUP_NS = 2000;
   localparam int EPV_FAST_PW_NS = 1000000;
   localparam int EPV_EXPR_PW_NS = 100000;
   localparam int EPV_OPW_MIN_NS = 2850000;
   localparam int EPV_OPW_MAX_NS = 78750000;
   localparam int EPV_ACC_NS = 200;
   // Derived cycle counts; least times round up
   localparam int EPV_SETUP_CYC = (EPV_SETUP_NS + EPV_CLK_NS - 1) / EPV_CLK_NS;
   localparam int EPV_FAST_PW_CYC = EPV_FAST_PW_NS / EPV_CLK_NS;
   localparam int EPV_EXPR_PW_CYC = EPV_EXPR_PW_NS / EPV_CLK_NS;
   localparam int EPV_OPW_MIN_CYC = (EPV_OPW_MIN_NS + EPV_CLK_NS - 1) / EPV_CLK_NS;
   localparam int EPV_OPW_MAX_CYC = EPV_OPW_MAX_NS / EPV_CLK_NS;
   localparam int EPV_ACC_CYC = (EPV_ACC_NS + EPV_CLK_NS - 1) / EPV_CLK_NS;
   localparam int EPV_TW = 20;
   // Sequencer states
   typedef enum logic [3:0] {
      EPV_IDLE, EPV_SETUP, EPV_PULSE, EPV_RECOVER, EPV_CHECK, EPV_OVER, EPV_READ, EPV_DONE
   } epv_state_type;
endpackage

// >>> core/epv_tmr_if.sv
// Interface between the sequencer and the pulse timer
`timescale 1ns/1ns
`default_nettype none
interface epv_tmr_if;
   logic start;
   logic [epv_pkg::EPV_TW-1:0] length;
   logic done;
   modport master (output start, output length, input done);
   modport timer (input start, input length, output done);
endinterface
`default_nettype wire

// >>> core/epv_timer.sv
// Cycle timer that measures pin set-up times and strobe pulse widths
`timescale 1ns/1ns
`default_nettype none
module epv_timer (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // Timer port
   epv_tmr_if.timer tmr
);
   import epv_pkg::*;
   typedef struct packed {
      logic [EPV_TW-1:0] cnt;
      logic busy;
      logic done;
   } epv_tmr_state_type;
   epv_tmr_state_type s_q, s_d;

   // Count down; done pulses one cycle when the count expires
   always_comb begin
      s_d = s_q;
      s_d.done = 1'b0;
      if (tmr.start) begin
         s_d.cnt = tmr.length;
         s_d.busy = 1'b1;
      end else if (s_q.busy) begin
         if (s_q.cnt <= {{(EPV_TW-1){1'b0}}, 1'b1}) begin
            s_d.busy = 1'b0;
            s_d.done = 1'b1;
         end else begin
            s_d.cnt = s_q.cnt - 1'b1;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
   assign tmr.done = s_q.done;
endmodule
`default_nettype wire

// >>> core/epv_ctrl.sv
// Pin-level programmer for a 16-bit UV PROM, commanded over AHB-Lite
//
// Function
// (RQ1) Fast or express pulse algorithm chosen
// (RQ2) Fast: pulses until verify, then overprogram
// (RQ3) Express: up to ten 100us pulses, no overprogram
// (RQ4) Program: high supply, gate high, select low, strobe
// (RQ5) Erased ones; programming only clears bits
// (RQ6) Address and data presented before strobing
// (RQ7) One low strobe pulse writes the word
// (RQ8) Read back and compare every bit
// (RQ9) Verify: high supply, gate low, strobe high
// (RQ10) Shared lines, separate strobe per device
// (RQ11) High strobe or select blocks writing
// (RQ12) Identity: identity pin elevated, select, gate low
// (RQ13) Code select picks maker or type byte
// (RQ14) Upper data byte reads zero in identity
// (RQ15) Identity codes may be read first
// (RQ16) Overprogram length from iteration count, bounded
// (RQ17) Gate high floats device data pins
// (RQ18) Select high gives standby, floated pins
// (RQ19) Express failure after ten pulses reported
//
// Decided for this implementation: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
module epv_ctrl #(
   parameter int OPW_MAX_CYC = epv_pkg::EPV_OPW_MAX_CYC,
   parameter int FAST_PW_CYC = epv_pkg::EPV_FAST_PW_CYC
) (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // PROM pins, shared
   output logic [epv_pkg::EPV_AW-1:0] address_pins,
   input wire logic [epv_pkg::EPV_DW-1:0] data_pins_i,
   output logic [epv_pkg::EPV_DW-1:0] data_pins_o,
   output logic data_pins_oe,
   output logic chip_select_n,
   output logic output_gate_n,
   output logic vpp_elevated,
   output logic identity_select_pin,
   // PROM strobes, one per device
   output logic [epv_pkg::EPV_NDEV-1:0] program_strobe_n
);
   import epv_pkg::*;

   typedef struct packed {
      epv_state_type st;
      logic [2:0] cmd;
      logic [EPV_NDEV-1:0] sel;
      logic [7:0] mult;
      logic [EPV_AW-1:0] addr;
      logic [EPV_DW-1:0] wdat;
      logic [EPV_DW-1:0] rdat;
      logic [7:0] iter;
      logic busy;
      logic pass;
      logic fail;
      logic over;
      logic [EPV_DW-1:0] din0;
      logic [EPV_DW-1:0] din1;
      logic aph;
      logic awr;
      logic [7:0] aoff;
      logic [31:0] hrdata;
      logic [EPV_AW-1:0] pa;
      logic [EPV_DW-1:0] pd;
      logic doe;
      logic cs_n;
      logic oe_n;
      logic vpp;
      logic idp;
      logic [EPV_NDEV-1:0] pgm_n;
   } epv_ctrl_state_type;
   epv_ctrl_state_type s_q, s_d;

   epv_tmr_if tmr ();
   epv_timer u_timer (
      .hclk(hclk),
      .hresetn(hresetn),
      .tmr(tmr)
   );

   logic [31:0] opw_cyc;
   logic [31:0] opw_req;
   logic [EPV_DW-1:0] din;
   logic [31:0] stat_word;

   // Overprogram length grows with iterations, clamped into the legal window
   always_comb begin
      opw_req = 32'(s_q.iter) * 32'(s_q.mult) * 32'(FAST_PW_CYC); // [RQ16]
      if (opw_req < 32'(EPV_OPW_MIN_CYC)) begin
         opw_cyc = 32'(EPV_OPW_MIN_CYC);
      end else if (opw_req > 32'(OPW_MAX_CYC)) begin
         opw_cyc = 32'(OPW_MAX_CYC);
      end else begin
         opw_cyc = opw_req;
      end
   end

   assign din = s_q.din1;
   assign stat_word = {26'h0, s_q.over, s_q.fail, s_q.pass, s_q.busy, 2'h0} | 32'(s_q.iter) << 8;

   // Bus slave, pin sequencer and read-back
   always_comb begin
      s_d = s_q;
      tmr.start = 1'b0;
      tmr.length = '0;
      // Read data come through two flops, they are asynchronous to hclk
      s_d.din0 = data_pins_i;
      s_d.din1 = s_q.din0;
      // Address phase capture
      s_d.aph = hsel && hready && htrans[1];
      s_d.awr = hwrite;
      s_d.aoff = haddr[7:0];
      if (hsel && hready && htrans[1] && !hwrite) begin
         case (haddr[7:0])
            EPV_OFF_CTRL: s_d.hrdata = {29'h0, s_q.cmd};
            EPV_OFF_ADDR: s_d.hrdata = 32'(s_q.addr);
            EPV_OFF_DATA: s_d.hrdata = 32'(s_q.wdat);
            EPV_OFF_STAT: s_d.hrdata = stat_word;
            EPV_OFF_RDAT: s_d.hrdata = 32'(s_q.rdat);
            EPV_OFF_OPT: s_d.hrdata = {16'h0, s_q.mult, 4'h0, s_q.sel};
            default: s_d.hrdata = 32'h0000_0000;
         endcase
      end
      // Write data phase; writes are ignored while a command runs
      if (s_q.aph && s_q.awr && !s_q.busy) begin
         case (s_q.aoff)
            EPV_OFF_ADDR: s_d.addr = hwdata[EPV_AW-1:0];
            EPV_OFF_DATA: s_d.wdat = hwdata[EPV_DW-1:0];
            EPV_OFF_OPT: begin
               s_d.sel = hwdata[EPV_OPT_SEL_LSB +: EPV_NDEV];
               s_d.mult = hwdata[EPV_OPT_MULT_LSB +: 8];
            end
            EPV_OFF_CTRL: begin
               s_d.cmd = hwdata[2:0];
               // Unknown codes are kept in the field but never run, so no stray pin walk
               if (hwdata[EPV_CTRL_GO_BIT] &&
                   (hwdata[2:0] == EPV_CMD_PROG || hwdata[2:0] == EPV_CMD_VERIFY ||
                    hwdata[2:0] == EPV_CMD_IDENT || hwdata[2:0] == EPV_CMD_EXPR)) begin
                  s_d.busy = 1'b1;
                  s_d.pass = 1'b0;
                  s_d.fail = 1'b0;
                  s_d.over = 1'b0;
                  s_d.iter = 8'h00;
                  s_d.st = EPV_SETUP;
               end
            end
            default: ;
         endcase
      end
      case (s_q.st)
         EPV_IDLE: begin
            // Standby: control pins and data driver released, address pins hold the last address, select high floats the device [RQ18]
            s_d.cs_n = 1'b1;
            s_d.oe_n = 1'b1;
            s_d.vpp = 1'b0;
            s_d.idp = 1'b0;
            s_d.doe = 1'b0;
            s_d.pgm_n = '1;
         end
         EPV_SETUP: begin
            // Present address, and data for program commands, raise levels, then wait set-up [RQ6]
            s_d.pa = s_q.addr;
            s_d.cs_n = 1'b0;
            s_d.pgm_n = '1; // [RQ11]
            if (s_q.cmd == EPV_CMD_IDENT) begin
               // Code select on the lowest address pin [RQ12] [RQ15]
               s_d.pa = '0;
               s_d.pa[0] = s_q.addr[EPV_OPT_CODE_BIT - 4];
               s_d.idp = 1'b1;
               s_d.vpp = 1'b0;
               s_d.oe_n = 1'b0;
               s_d.doe = 1'b0;
            end else if (s_q.cmd == EPV_CMD_VERIFY) begin
               s_d.vpp = 1'b1;
               s_d.oe_n = 1'b0; // [RQ9]
               s_d.doe = 1'b0;
            end else begin
               s_d.vpp = 1'b1;
               s_d.oe_n = 1'b1; // Gate high keeps device outputs off [RQ17]
               s_d.pd = s_q.wdat;
               s_d.doe = 1'b1;
            end
            tmr.start = 1'b1;
            tmr.length = EPV_TW'(EPV_SETUP_CYC);
            s_d.st = (s_q.cmd == EPV_CMD_PROG || s_q.cmd == EPV_CMD_EXPR) ?
               EPV_PULSE : EPV_READ;
         end
         EPV_PULSE: if (tmr.done) begin
            // Strobe only selected devices, others stay inhibited [RQ4] [RQ7] [RQ10]
            s_d.pgm_n = ~s_q.sel;
            s_d.iter = s_q.iter + 8'h01;
            tmr.start = 1'b1;
            tmr.length = (s_q.cmd == EPV_CMD_EXPR) ? EPV_TW'(EPV_EXPR_PW_CYC) :
               EPV_TW'(FAST_PW_CYC); // [RQ1]
            s_d.st = EPV_RECOVER;
         end
         EPV_RECOVER: if (tmr.done) begin
            // End the pulse, hold data, then turn the bus round for verify
            s_d.pgm_n = '1;
            tmr.start = 1'b1;
            tmr.length = EPV_TW'(EPV_SETUP_CYC);
            s_d.st = EPV_CHECK;
         end
         EPV_CHECK: if (tmr.done) begin
            if (s_q.doe) begin
               s_d.doe = 1'b0;
               s_d.oe_n = 1'b0;
               tmr.start = 1'b1;
               tmr.length = EPV_TW'(EPV_ACC_CYC + 2);
            end else begin
               s_d.rdat = din;
               s_d.oe_n = 1'b1;
               // The shared data pins are read back, whichever devices are selected
               if (din == s_q.wdat) begin // [RQ8]
                  if (s_q.cmd == EPV_CMD_EXPR || s_q.over) begin
                     s_d.pass = 1'b1; // Express: no overprogram [RQ3]
                     s_d.st = EPV_DONE;
                  end else begin
                     s_d.over = 1'b1; // [RQ2]
                     s_d.pd = s_q.wdat;
                     s_d.doe = 1'b1;
                     tmr.start = 1'b1;
                     tmr.length = EPV_TW'(EPV_SETUP_CYC);
                     s_d.st = EPV_OVER;
                  end
               end else if ((s_q.cmd == EPV_CMD_EXPR && s_q.iter >= 8'(EPV_EXPR_MAX)) ||
                            (s_q.cmd != EPV_CMD_EXPR && s_q.iter >= EPV_FAST_MAX) ||
                            ((din & ~s_q.wdat) != '0 && s_q.over)) begin
                  // Pulse limit reached, or after overprogram a bit that must be zero still reads one [RQ5] [RQ19]
                  s_d.fail = 1'b1;
                  s_d.st = EPV_DONE;
               end else begin
                  s_d.pd = s_q.wdat;
                  s_d.doe = 1'b1;
                  tmr.start = 1'b1;
                  tmr.length = EPV_TW'(EPV_SETUP_CYC);
                  s_d.st = EPV_PULSE;
               end
            end
         end
         EPV_OVER: if (tmr.done) begin
            s_d.pgm_n = ~s_q.sel;
            tmr.start = 1'b1;
            tmr.length = opw_cyc[EPV_TW-1:0]; // [RQ16]
            s_d.st = EPV_RECOVER;
         end
         EPV_READ: if (tmr.done) begin
            if (s_q.cmd == EPV_CMD_IDENT) begin
               s_d.rdat = {8'h00, din[EPV_IDW-1:0]}; // [RQ13] [RQ14]
            end else begin
               s_d.rdat = din;
            end
            s_d.pass = 1'b1;
            s_d.st = EPV_DONE;
         end
         EPV_DONE: begin
            s_d.busy = 1'b0;
            s_d.st = EPV_IDLE;
         end
         default: s_d.st = EPV_IDLE;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_q <= '{st: EPV_IDLE, mult: EPV_OPW_MULT_DEF, sel: {{(EPV_NDEV-1){1'b0}}, 1'b1},
                  cs_n: 1'b1, oe_n: 1'b1, pgm_n: '1, default: '0};
      end else begin
         s_q <= s_d;
      end
   end

   // Zero-wait slave, always OKAY
   assign hrdata = s_q.hrdata;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign address_pins = s_q.pa;
   assign data_pins_o = s_q.pd;
   assign data_pins_oe = s_q.doe;
   assign chip_select_n = s_q.cs_n;
   assign output_gate_n = s_q.oe_n;
   assign vpp_elevated = s_q.vpp;
   assign identity_select_pin = s_q.idp;
   assign program_strobe_n = s_q.pgm_n;
endmodule
`default_nettype wire

// >>> tb/epv_ctrl_assertions.sv
// Checker on the PROM programmer's pins
`timescale 1ns/1ns
`default_nettype none
module epv_ctrl_assertions import epv_pkg::*; #(
   parameter int FAST_PW_CYC = EPV_FAST_PW_CYC
) (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // Bus answer
   input wire logic hreadyout,
   input wire logic hresp,
   // PROM pins
   input wire logic [EPV_AW-1:0] address_pins,
   input wire logic [EPV_DW-1:0] data_pins_o,
   input wire logic data_pins_oe,
   input wire logic chip_select_n,
   input wire logic output_gate_n,
   input wire logic vpp_elevated,
   input wire logic identity_select_pin,
   input wire logic [EPV_NDEV-1:0] program_strobe_n
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   wire logic low = ~&program_strobe_n;
   logic [19:0] low_cnt_q, low_cnt_d;
   // Length of the strobe pulse in progress
   always_comb low_cnt_d = low ? low_cnt_q + 20'h1 : 20'h0;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) low_cnt_q <= 20'h0;
      else low_cnt_q <= low_cnt_d;
   end
   sequence s_pulse_end;
      $past(low) && !low;
   endsequence
   sequence s_hold;
      data_pins_oe && $stable(data_pins_o) && $stable(address_pins);
   endsequence
   property p_prog_pins;
      low |-> vpp_elevated && output_gate_n && !chip_select_n && data_pins_oe && !identity_select_pin;
   endproperty
   property p_pulse_steady;
      low && $past(low) |-> $stable(program_strobe_n) && $stable(data_pins_o) && $stable(address_pins);
   endproperty
   // Pins set well before the strobe; a margin of two cycles allows for timer start
   property p_setup;
      $rose(low) |-> $past(data_pins_oe, 18) && $past(vpp_elevated, 18) && $past(address_pins, 18) == address_pins;
   endproperty
   property p_width;
      s_pulse_end |-> low_cnt_q >= FAST_PW_CYC;
   endproperty
   property p_hold;
      s_pulse_end |-> s_hold [*8];
   endproperty
   property p_verify;
      !output_gate_n |-> !data_pins_oe && !low;
   endproperty
   property p_ident;
      identity_select_pin |-> !vpp_elevated && !low && address_pins[13:1] == 13'h0;
   endproperty
   property p_bus;
      hreadyout && !hresp;
   endproperty
   a_prog_pins: assert property (p_prog_pins) else $error("program pins wrong");
   a_pulse_steady: assert property (p_pulse_steady) else $error("pins moved in pulse");
   a_setup: assert property (p_setup) else $error("setup too short");
   a_width: assert property (p_width) else $error("pulse too short");
   a_hold: assert property (p_hold) else $error("data hold broken");
   a_verify: assert property (p_verify) else $error("contention on read");
   a_ident: assert property (p_ident) else $error("identity pins wrong");
   a_bus: assert property (p_bus) else $error("bus answer wrong");
endmodule
bind epv_ctrl epv_ctrl_assertions #(.FAST_PW_CYC(FAST_PW_CYC)) epv_ctrl_assertions_i (.hclk, .hresetn,
   .hreadyout, .hresp, .address_pins, .data_pins_o, .data_pins_oe, .chip_select_n, .output_gate_n,
   .vpp_elevated, .identity_select_pin, .program_strobe_n);
`default_nettype wire

// >>> tb/epv_prom_model.sv
// Behavioural model of one 16-bit UV PROM
`timescale 1ns/1ns
`default_nettype none
module epv_prom_model #(
   parameter logic [7:0] MAKER_CODE = 8'h5A, // Arbitrary value
   parameter logic [7:0] TYPE_CODE = 8'hC3 // Arbitrary value
) (
   // Pins from the programmer
   input wire logic [13:0] address_pins,
   input wire logic [15:0] data_pins,
   input wire logic program_strobe_n,
   input wire logic chip_select_n,
   input wire logic output_gate_n,
   input wire logic vpp_elevated,
   input wire logic identity_select_pin,
   // Pulses a cell needs before it takes its value
   input wire logic [3:0] need,
   // Data back to the pins
   output logic [15:0] data_q,
   output logic data_en
);
   logic [15:0] mem [0:16383];
   logic [3:0] hits [0:16383];
   logic [15:0] last;
   wire logic prog = vpp_elevated && output_gate_n && !chip_select_n;
   wire logic [15:0] word = identity_select_pin ?
      {8'h00, address_pins[0] ? TYPE_CODE : MAKER_CODE} : mem[address_pins];
   // Erased array
   initial begin
      last = 16'h0000;
      for (int i = 0; i < 16384; i++) begin
         mem[i] = 16'hFFFF;
         hits[i] = 4'h0;
      end
   end
   // End of a write pulse; slow cells need several
   always @(posedge program_strobe_n) begin
      if (prog) begin
         hits[address_pins] = hits[address_pins] + 4'h1;
         if (hits[address_pins] >= need) mem[address_pins] = mem[address_pins] & data_pins;
      end
   end
   // Floated pins show a flipped last value so stale data cannot pass
   assign data_en = !chip_select_n && !output_gate_n && program_strobe_n;
   always @* begin
      if (data_en) last = word;
   end
   assign data_q = data_en ? word : ~last;
endmodule
`default_nettype wire

// >>> tb/test_epv_ctrl.sv
// Testbench of the PROM programmer
`timescale 1ns/1ns
`default_nettype none
module test_epv_ctrl;
   import epv_pkg::*;
   localparam logic [7:0] MAKER = 8'h5A; // Arbitrary value
   localparam logic [7:0] KIND = 8'hC3; // Arbitrary value
   typedef struct {logic [2:0] cmd; logic [13:0] addr; logic [15:0] data; logic [3:0] need;
      logic [31:0] mask; logic [31:0] stat; logic [31:0] rdat;} epv_row_type;
   logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
   logic [1:0] htrans = 0;
   logic [2:0] hsize = 0;
   logic hreadyout, hresp, data_pins_oe, chip_select_n, output_gate_n, vpp_elevated;
   logic identity_select_pin, en0, en1;
   logic [13:0] address_pins;
   logic [15:0] data_pins_o, q0, q1;
   logic [3:0] program_strobe_n, need0 = 4'h1;
   wire logic [15:0] pins = data_pins_oe ? data_pins_o : (en0 ? q0 : q1);
   int fails = 0, num_checks = 0, cyc = 0;
   epv_row_type rows [7] = '{
      '{EPV_CMD_IDENT, 14'h0, 16'h0, 4'h1, 32'h0, 32'h0, {24'h0, MAKER}},
      '{EPV_CMD_IDENT, 14'h1, 16'h0, 4'h1, 32'h0, 32'h0, {24'h0, KIND}},
      '{EPV_CMD_EXPR, 14'h5, 16'h1234, 4'h3, 32'hFF1C, 32'h0308, 32'h1234},
      '{EPV_CMD_VERIFY, 14'h5, 16'h0, 4'h1, 32'h0, 32'h0, 32'h1234},
      '{EPV_CMD_VERIFY, 14'h6, 16'h0, 4'h1, 32'h0, 32'h0, 32'hFFFF},
      '{EPV_CMD_PROG, 14'h8, 16'h00F0, 4'h2, 32'h3C, 32'h28, 32'h00F0},
      '{EPV_CMD_EXPR, 14'h9, 16'h0, 4'hF, 32'hFF1C, 32'h0A10, 32'hFFFF}};
   always #50 hclk = ~hclk;
   epv_ctrl #(.OPW_MAX_CYC(1000), .FAST_PW_CYC(20)) epv_ctrl_i (.hclk(hclk), .hresetn(hresetn),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .address_pins(address_pins), .data_pins_i(pins), .data_pins_o(data_pins_o),
      .data_pins_oe(data_pins_oe), .chip_select_n(chip_select_n), .output_gate_n(output_gate_n),
      .vpp_elevated(vpp_elevated), .identity_select_pin(identity_select_pin),
      .program_strobe_n(program_strobe_n));
   epv_prom_model #(.MAKER_CODE(MAKER), .TYPE_CODE(KIND)) dev0_i (.address_pins(address_pins),
      .data_pins(pins), .program_strobe_n(program_strobe_n[0]), .chip_select_n(chip_select_n),
      .output_gate_n(output_gate_n), .vpp_elevated(vpp_elevated),
      .identity_select_pin(identity_select_pin), .need(need0), .data_q(q0), .data_en(en0));
   epv_prom_model #(.MAKER_CODE(MAKER), .TYPE_CODE(KIND)) dev1_i (.address_pins(address_pins),
      .data_pins(pins), .program_strobe_n(program_strobe_n[1]), .chip_select_n(chip_select_n),
      .output_gate_n(output_gate_n), .vpp_elevated(vpp_elevated),
      .identity_select_pin(identity_select_pin), .need(4'h1), .data_q(q1), .data_en(en1));
   task complete_run;
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
         fails++;
      end
   endtask
   // One single word transfer; waits for hready in both phases
   task xfer(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] r);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= {24'h0, a};
      hwrite <= w;
      hsize <= 3'b010;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask
   task start(input logic [2:0] c, input logic [13:0] a, input logic [15:0] d);
      xfer(1'b1, EPV_OFF_ADDR, {18'h0, a}, rd);
      xfer(1'b1, EPV_OFF_DATA, {16'h0, d}, rd);
      xfer(1'b1, EPV_OFF_CTRL, {29'h0, c} | 32'h80000000, rd);
   endtask
   task finish_op;
      do xfer(1'b0, EPV_OFF_STAT, 32'h0, rd); while (rd[2] !== 1'b0);
   endtask
   // A hang counts as a mismatch
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (cyc == 95000) begin
         fails = fails + 1;
         complete_run;
      end
   end
   initial begin
      repeat (20) @(posedge hclk);
      chk({chip_select_n, output_gate_n, program_strobe_n, vpp_elevated, identity_select_pin,
         data_pins_oe}, 32'h1F8);
      hresetn <= 1'b1;
      xfer(1'b0, EPV_OFF_STAT, 32'h0, rd);
      chk(rd & 32'hFF3C, 32'h0);
      xfer(1'b0, EPV_OFF_OPT, 32'h0, rd);
      chk(rd, 32'h301);
      xfer(1'b1, 8'h18, 32'hFFFF, rd);
      xfer(1'b0, 8'h18, 32'h0, rd);
      chk(rd, 32'h0);
      for (int i = 0; i < 7; i++) begin
         need0 <= rows[i].need;
         start(rows[i].cmd, rows[i].addr, rows[i].data);
         finish_op;
         chk(rd & rows[i].mask, rows[i].stat);
         xfer(1'b0, EPV_OFF_RDAT, 32'h0, rd);
         chk(rd, rows[i].rdat);
      end
      // Strobe only the second device; the first must keep its erased word
      need0 <= 4'h1;
      xfer(1'b1, EPV_OFF_OPT, 32'h302, rd);
      start(EPV_CMD_EXPR, 14'h7, 16'h0);
      xfer(1'b1, EPV_OFF_ADDR, 32'h3, rd);
      finish_op;
      xfer(1'b0, EPV_OFF_ADDR, 32'h0, rd);
      chk(rd, 32'h7);
      xfer(1'b1, EPV_OFF_OPT, 32'h301, rd);
      start(EPV_CMD_VERIFY, 14'h7, 16'h0);
      finish_op;
      xfer(1'b0, EPV_OFF_RDAT, 32'h0, rd);
      chk(rd, 32'hFFFF);
      // An unknown command code with go set must leave the sequencer idle
      xfer(1'b1, EPV_OFF_CTRL, 32'h80000005, rd);
      xfer(1'b0, EPV_OFF_STAT, 32'h0, rd);
      chk(rd & 32'h4, 32'h0);
      // Reset while a command waits out its set-up drops every pin to standby at once
      start(EPV_CMD_EXPR, 14'hA, 16'h0);
      repeat (5) @(posedge hclk);
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      chk({chip_select_n, output_gate_n, program_strobe_n, vpp_elevated, identity_select_pin,
         data_pins_oe}, 32'h1F8);
      hresetn <= 1'b1;
      xfer(1'b0, EPV_OFF_STAT, 32'h0, rd);
      chk(rd & 32'hFF3C, 32'h0);
      complete_run;
   end
endmodule
`default_nettype wire
